// *** rtl/pmr_result_regs.sv ***
// Purpose: Result registers, averaging and energy and charge accumulators.
// Assumes: Register port from the serial front end; samples from the converter.
// Notes: Summary of operation follows.
// Summary of operation
// - Current result at 0x07: 16-bit two's complement, 1.2 mA per code.
// - Bus voltage at 0x05: 16-bit signed, never negative, 3.125 mV per code.
// - Bus voltage code range spans 102.4 V though measurement stops at 85 V.
// - Die temperature at 0x06: 12-bit signed, 125 milli-degree per code.
// - All signed results use two's complement.
// - Power at 0x08: 24-bit unsigned, 240 microwatt per code, host readable.
// - Energy at 0x09: 40-bit unsigned, wraps on overflow, keeping the low 40 bits of the sum.
// - Accumulator clear bit zeroes the energy accumulator at any time.
// - Charge at 0x0A: 40-bit unsigned, overflow sets the charge overflow flag.
// - Eight conversion times from 50 to 4120 microseconds are selectable.
// - Averaging counts including 1, 4 and 16 are selectable.
// - Output period equals conversion time times averaging count.
// - Multi-byte registers go out most significant byte first.
`timescale 1ns/100ps
module pmr_result_regs (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire pmr_pkg::pmr_sample_t SAMPLE,
   input wire pmr_pkg::pmr_req_t REQ,
   input wire logic REQ_VALID,
   input wire logic BYTE_NEXT,
   output logic [7:0] RD_BYTE,
   output logic [2:0] RD_LEN,
   output logic CONV_TICK,
   output logic OUT_TICK
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [2:0] ct_ff;
   logic [2:0] avg_ff;
   logic charge_of_ff;
   logic [26:0] cur_sum_ff;
   logic [26:0] vb_sum_ff;
   logic [22:0] tmp_sum_ff;
   logic [15:0] cur_res_ff;
   logic [15:0] vb_res_ff;
   logic [11:0] tmp_res_ff;
   logic [23:0] pwr_res_ff;
   logic [39:0] energy_ff;
   logic [39:0] charge_ff;
   logic [39:0] shreg_ff;
   logic [2:0] len_ff;
   logic [7:0] rd_byte_ff;
   wire conv_tick;
   wire out_tick;
   wire wr_hit;
   wire rd_hit;
   wire acc_clear;
   wire [3:0] shift_amt;
   wire [15:0] cur_avg;
   wire [15:0] vb_avg;
   wire [11:0] tmp_avg;
   wire [26:0] cur_acc;
   wire [26:0] vb_acc;
   wire [22:0] tmp_acc;
   wire [15:0] cur_mag;
   wire [31:0] pwr_prod;
   wire [40:0] energy_sum;
   wire [40:0] charge_sum;
   wire [39:0] rd_word;
   wire [2:0] rd_len;

   // Log2 of the averaging count for a selection.
   function automatic logic [3:0] avg_shift(input logic [2:0] sel);
      case (sel)
         3'h0: avg_shift = 4'h0;
         3'h1: avg_shift = 4'h2;
         3'h2: avg_shift = 4'h4;
         3'h3: avg_shift = 4'h6;
         3'h4: avg_shift = 4'h7;
         3'h5: avg_shift = 4'h8;
         3'h6: avg_shift = 4'h9;
         default: avg_shift = 4'hA;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Conversion and output sample timing.
   pmr_rate_gen u_rate (
      .clk(CLOCK),
      .rst_n(RST_N),
      .ct_sel(ct_ff),
      .avg_sel(avg_ff),
      .conv_tick(conv_tick),
      .out_tick(out_tick)
   );
   assign CONV_TICK = conv_tick;
   assign OUT_TICK = out_tick;

   ////////////////////////////////////////////////////////////////////////
   // Register port decode.
   assign wr_hit = REQ_VALID & REQ.wr;
   assign rd_hit = REQ_VALID & ~REQ.wr;
   assign acc_clear = wr_hit & (REQ.ptr == pmr_pkg::OFS_CONFIG)
                      & REQ.wdata[pmr_pkg::CFG_ACC_CLEAR_BIT];

   // Configuration storage; the clear bit is self-clearing and not stored.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         ct_ff <= pmr_pkg::CT_RESET;
         avg_ff <= pmr_pkg::AVG_RESET;
      end else if (wr_hit && REQ.ptr == pmr_pkg::OFS_ADC_CONFIG) begin
         ct_ff <= REQ.wdata[pmr_pkg::ADC_CT_LSB +: 3];
         avg_ff <= REQ.wdata[pmr_pkg::ADC_AVG_LSB +: 3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Averaging of signed samples with arithmetic shift by log2 of the count.
   // The sample of the closing conversion is part of the window it closes.
   assign shift_amt = avg_shift(avg_ff);
   assign cur_acc = cur_sum_ff + 27'($signed(SAMPLE.current));
   assign vb_acc = vb_sum_ff + 27'($signed(SAMPLE.bus_voltage));
   assign tmp_acc = tmp_sum_ff + 23'($signed(SAMPLE.die_temp));
   assign cur_avg = 16'($signed(cur_acc) >>> shift_amt);
   assign vb_avg = 16'($signed(vb_acc) >>> shift_amt);
   assign tmp_avg = 12'($signed(tmp_acc) >>> shift_amt);

   // Sum samples each conversion and restart on every output sample.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cur_sum_ff <= 27'h0000000;
         vb_sum_ff <= 27'h0000000;
         tmp_sum_ff <= 23'h000000;
      end else if (out_tick) begin
         cur_sum_ff <= 27'h0000000;
         vb_sum_ff <= 27'h0000000;
         tmp_sum_ff <= 23'h000000;
      end else if (conv_tick) begin
         cur_sum_ff <= cur_acc;
         vb_sum_ff <= vb_acc;
         tmp_sum_ff <= tmp_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power is the magnitude of current times bus voltage; one power code is 64 products.
   assign cur_mag = cur_res_ff[15] ? 16'(-cur_res_ff) : cur_res_ff;
   assign pwr_prod = 32'(cur_mag) * 32'(vb_res_ff);

   // Publish current, voltage and temperature once per averaged output sample; power follows one cycle later.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cur_res_ff <= 16'h0000;
         vb_res_ff <= 16'h0000;
         tmp_res_ff <= 12'h000;
         pwr_res_ff <= 24'h000000;
      end else begin
         if (out_tick) begin
            cur_res_ff <= cur_avg;
            vb_res_ff <= vb_avg[15] ? 16'h0000 : vb_avg;
            tmp_res_ff <= tmp_avg;
         end
         pwr_res_ff <= pwr_prod[29:6];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Energy wraps and charge flags overflow; clear wins over accumulation.
   assign energy_sum = {1'b0, energy_ff} + {17'h00000, pwr_res_ff};
   assign charge_sum = {1'b0, charge_ff} + {25'h0000000, cur_mag};

   // An overflow that falls in the clearing cycle still sets the flag.

   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         energy_ff <= pmr_pkg::ACC_RESET;
         charge_ff <= pmr_pkg::ACC_RESET;
         charge_of_ff <= 1'b0;
      end else if (acc_clear) begin
         energy_ff <= pmr_pkg::ACC_RESET;
         charge_ff <= pmr_pkg::ACC_RESET;
         charge_of_ff <= out_tick & charge_sum[40];
      end else if (out_tick) begin
         energy_ff <= energy_sum[39:0];
         charge_ff <= charge_sum[39:0];
         charge_of_ff <= charge_of_ff | charge_sum[40];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read selection, left-aligned so the top byte leaves first.
   assign rd_word = (REQ.ptr == pmr_pkg::OFS_BUS_VOLTAGE) ? {vb_res_ff, 24'h000000} :
                    (REQ.ptr == pmr_pkg::OFS_DIE_TEMP) ? {tmp_res_ff, 4'h0, 24'h000000} :
                    (REQ.ptr == pmr_pkg::OFS_CURRENT) ? {cur_res_ff, 24'h000000} :
                    (REQ.ptr == pmr_pkg::OFS_POWER) ? {pwr_res_ff, 16'h0000} :
                    (REQ.ptr == pmr_pkg::OFS_ENERGY) ? energy_ff :
                    (REQ.ptr == pmr_pkg::OFS_CHARGE) ? charge_ff :
                    (REQ.ptr == pmr_pkg::OFS_ADC_CONFIG) ?
                       {10'h000, ct_ff, avg_ff, 24'h000000} :
                    (REQ.ptr == pmr_pkg::OFS_DIAG) ?
                       {15'h0000, charge_of_ff, 24'h000000} : 40'h00_0000_0000;
   assign rd_len = (REQ.ptr == pmr_pkg::OFS_POWER) ? 3'h3 :
                   (REQ.ptr == pmr_pkg::OFS_ENERGY || REQ.ptr == pmr_pkg::OFS_CHARGE) ?
                   3'h5 : 3'h2;

   // Snapshot on read, then shift out most significant byte first.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         shreg_ff <= 40'h00_0000_0000;
         len_ff <= 3'h0;
         rd_byte_ff <= 8'h00;
      end else if (rd_hit) begin
         shreg_ff <= {rd_word[31:0], 8'h00};
         len_ff <= rd_len;
         rd_byte_ff <= rd_word[39:32];
      end else if (BYTE_NEXT && len_ff != 3'h0) begin
         shreg_ff <= {shreg_ff[31:0], 8'h00};
         len_ff <= len_ff - 3'h1;
         rd_byte_ff <= shreg_ff[39:32];
      end
   end
   assign RD_BYTE = rd_byte_ff;
   assign RD_LEN = len_ff;
endmodule

// *** rtl/pmr_pkg.sv ***
// Purpose: Shared constants and types for the power monitor result registers.
// Assumes: 100 MHz clock; register pointer values as printed offsets.
// Notes: Conversion times are in microseconds; cycle counts derive from them.
package pmr_pkg;
   localparam int CLK_MHZ = 100;
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_ADC_CONFIG = 8'h01;
   localparam logic [7:0] OFS_DIAG = 8'h0B;
   localparam logic [7:0] OFS_BUS_VOLTAGE = 8'h05;
   localparam logic [7:0] OFS_DIE_TEMP = 8'h06;
   localparam logic [7:0] OFS_CURRENT = 8'h07;
   localparam logic [7:0] OFS_POWER = 8'h08;
   localparam logic [7:0] OFS_ENERGY = 8'h09;
   localparam logic [7:0] OFS_CHARGE = 8'h0A;
   localparam int CFG_ACC_CLEAR_BIT = 14;
   localparam int ADC_CT_LSB = 3;
   localparam int ADC_AVG_LSB = 0;
   localparam int DIAG_CHARGE_OF_BIT = 0;
   localparam logic [2:0] CT_RESET = 3'h0;
   localparam logic [2:0] AVG_RESET = 3'h0;
   localparam logic [15:0] BUS_VOLT_MAX_CODE = 16'h7FFF;
   localparam int CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
   localparam int AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
   localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

   // Raw measurement sample from the converter front end.
   typedef struct packed {
      logic [15:0] current;
      logic [15:0] bus_voltage;
      logic [11:0] die_temp;
   } pmr_sample_t;

   // Host-side register port access.
   typedef struct packed {
      logic wr;
      logic [7:0] ptr;
      logic [15:0] wdata;
   } pmr_req_t;
endpackage

// *** rtl/pmr_rate_gen.sv ***
// Purpose: Conversion-time and averaging tick generator.
// Assumes: One clock; selection fields stable or changed at any time.
// Notes: conv_tick marks each conversion, out_tick each averaged output.
`timescale 1ns/100ps
module pmr_rate_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] ct_sel,
   input wire logic [2:0] avg_sel,
   output logic conv_tick,
   output logic out_tick
);
   logic [18:0] cyc_ff;
   logic [10:0] avg_ff;
   wire [18:0] cyc_last;
   wire [10:0] avg_last;
   wire conv_end;
   wire avg_end;

   // Last cycle index of a conversion and last conversion index of an output sample, for the selections.
   assign cyc_last = 19'(pmr_pkg::CT_US[ct_sel] * pmr_pkg::CLK_MHZ - 1);
   assign avg_last = 11'(pmr_pkg::AVG_N[avg_sel] - 1);
   assign conv_end = (cyc_ff >= cyc_last);
   assign avg_end = (avg_ff >= avg_last);
   assign conv_tick = conv_end;
   assign out_tick = conv_end & avg_end;

   // Count cycles per conversion and conversions per output sample.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cyc_ff <= 19'h00000;
         avg_ff <= 11'h000;
      end else if (conv_end) begin
         cyc_ff <= 19'h00000;
         avg_ff <= avg_end ? 11'h000 : avg_ff + 11'h001;
      end else begin
         cyc_ff <= cyc_ff + 19'h00001;
      end
   end
endmodule

// *** dv/pmr_result_regs_assertions.sv ***
// Purpose: Port checks for the result registers.
// Assumes: A read answers one cycle after it is taken.
// Notes: Sees only the top-level ports.
`timescale 1ns/100ps
module pmr_result_regs_assertions (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire pmr_pkg::pmr_req_t REQ,
   input wire logic REQ_VALID,
   input wire logic BYTE_NEXT,
   input wire logic [7:0] RD_BYTE,
   input wire logic [2:0] RD_LEN,
   input wire logic CONV_TICK,
   input wire logic OUT_TICK
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   //////////////////////////////////////////////////
   // Read requests and byte advances, named once.
   wire rd = REQ_VALID && !REQ.wr;
   wire adv = BYTE_NEXT && !REQ_VALID;
   property p_len_energy; rd && REQ.ptr == 8'h09 |=> RD_LEN == 3'h5; endproperty
   a_len_energy: assert property (p_len_energy) else $error("energy length");
   property p_len_charge; rd && REQ.ptr == 8'h0A |=> RD_LEN == 3'h5; endproperty
   a_len_charge: assert property (p_len_charge) else $error("charge length");
   property p_len_power; rd && REQ.ptr == 8'h08 |=> RD_LEN == 3'h3; endproperty
   a_len_power: assert property (p_len_power) else $error("power length");
   property p_len_word; rd && REQ.ptr inside {8'h06, 8'h07} |=> RD_LEN == 3'h2; endproperty
   a_len_word: assert property (p_len_word) else $error("word length");
   property p_volt_pos; rd && REQ.ptr == 8'h05 |=> RD_LEN == 3'h2 && !RD_BYTE[7]; endproperty
   a_volt_pos: assert property (p_volt_pos) else $error("bus voltage negative");
   property p_step; adv && RD_LEN != 3'h0 |=> RD_LEN == $past(RD_LEN) - 3'h1; endproperty
   a_step: assert property (p_step) else $error("byte count step");
   property p_hold; !REQ_VALID && !BYTE_NEXT |=> $stable(RD_BYTE) && $stable(RD_LEN); endproperty
   a_hold: assert property (p_hold) else $error("read byte moved");
   property p_conv_gap; CONV_TICK |=> !CONV_TICK [*8]; endproperty
   a_conv_gap: assert property (p_conv_gap) else $error("conversion too soon");
   property p_out_gap; OUT_TICK |=> !OUT_TICK [*8]; endproperty
   a_out_gap: assert property (p_out_gap) else $error("output too soon");
endmodule

// *** dv/pmr_host_model.sv ***
// Purpose: Host side of the register port.
// Assumes: Requests change just after a rising edge.
// Notes: Bytes are gathered most significant first.
`timescale 1ns/100ps
module pmr_host_model (
   input wire logic CLOCK,
   output pmr_pkg::pmr_req_t REQ,
   output logic REQ_VALID,
   output logic BYTE_NEXT,
   input wire logic [7:0] RD_BYTE,
   input wire logic [2:0] RD_LEN
);
   // Idle from time zero.
   initial begin
      REQ = '0;
      REQ_VALID = 1'b0;
      BYTE_NEXT = 1'b0;
   end
   // One request, held to the edge that takes it, then scrambled.
   task automatic put(input logic wr, input logic [7:0] ptr, input logic [15:0] d);
      REQ = '{wr, ptr, d};
      REQ_VALID = 1'b1;
      @(posedge CLOCK);
      #1 REQ_VALID = 1'b0;
      REQ = ~REQ;
      @(posedge CLOCK);
      #1;
   endtask
   // Reads n bytes of one register.
   task automatic get(input logic [7:0] ptr, input int n, output logic [39:0] v,
         output logic [2:0] len);
      put(1'b0, ptr, 16'h0000);
      len = RD_LEN;
      v = '0;
      for (int i = 0; i < n; i++) begin
         v = {v[31:0], RD_BYTE};
         if (i < n - 1) begin
            BYTE_NEXT = 1'b1;
            @(posedge CLOCK);
            #1;
         end
      end
      BYTE_NEXT = 1'b0;
   endtask
endmodule

// *** dv/pmr_result_regs_test.sv ***
// Purpose: Self-checking bench for the result registers.
// Assumes: Fastest conversion and no averaging after reset.
// Notes: Expected values come from an integer model.
`timescale 1ns/100ps
module pmr_result_regs_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pmr_pkg::pmr_sample_t smp = '0;
   pmr_pkg::pmr_req_t req;
   logic req_v, byte_next, conv_tick, out_tick;
   logic [7:0] rd_byte;
   logic [2:0] rd_len;
   int fails = 0;
   int checks_done = 0;
   int convs = 0;
   logic [31:0] seed = 32'h60DA;
   logic [7:0] ofs [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C};
   int lens [7] = '{2, 2, 2, 3, 5, 5, 2};
   logic [2:0] cts [2] = '{3'h1, 3'h0};
   logic [2:0] avs [2] = '{3'h0, 3'h1};
   pmr_result_regs dut_u (.CLOCK(clk), .RST_N(rst_n), .SAMPLE(smp), .REQ(req),
      .REQ_VALID(req_v), .BYTE_NEXT(byte_next), .RD_BYTE(rd_byte), .RD_LEN(rd_len),
      .CONV_TICK(conv_tick), .OUT_TICK(out_tick));
   pmr_host_model host_u (.CLOCK(clk), .REQ(req), .REQ_VALID(req_v),
      .BYTE_NEXT(byte_next), .RD_BYTE(rd_byte), .RD_LEN(rd_len));
   //////////////////////////////////////////////////
   // Free-running clock.
   initial begin
      forever #5 clk = ~clk;
   end
   // Compares and reports.
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask
   task automatic conclude();
      if (fails == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Counts cycles up to the one in which the next output tick stands.
   task automatic wait_out(output int n);
      n = 0;
      convs = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         convs += (conv_tick === 1'b1) ? 1 : 0;
      end while (out_tick !== 1'b1 && n < 30000);
      repeat (3) @(posedge clk);
      #1;
      if (n >= 30000) begin
         fails++;
         conclude();
      end
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   //////////////////////////////////////////////////
   // Main sequence.
   initial begin
      logic [39:0] v, e1, c1;
      logic [2:0] len;
      logic signed [15:0] cur, vb;
      int n, ia, vm;
      longint pw;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (ofs[i]) begin
         host_u.get(ofs[i], lens[i], v, len);
         check("reset value", v, 40'h0);
         check("length", {37'h0, len}, 40'(lens[i]));
      end
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         cur = seed[15:0];
         vb = {k[0], seed[30:16]};
         smp = '{cur, vb, seed[27:16]};
         host_u.put(1'b1, 8'h07, 16'hFFFF);
         wait_out(n);
         wait_out(n);
         ia = (cur < 0) ? -int'(cur) : int'(cur);
         vm = (vb < 0) ? 0 : int'(vb);
         pw = (longint'(ia) * 1200 * vm * 3125) / 240000000;
         host_u.get(8'h07, 2, v, len);
         check("current", v, {24'h0, cur});
         host_u.get(8'h05, 2, v, len);
         check("bus voltage", v, 40'(vm));
         host_u.get(8'h06, 2, v, len);
         check("die temp", v, {24'h0, seed[27:16], 4'h0});
         host_u.get(8'h08, 3, v, len);
         check("power", v, 40'(pw));
         if (k == 0) begin
            host_u.get(8'h09, 5, e1, len);
            host_u.get(8'h0A, 5, c1, len);
            wait_out(n);
            host_u.get(8'h09, 5, v, len);
            check("energy step", v - e1, 40'(pw));
            host_u.get(8'h0A, 5, v, len);
            check("charge step", v - c1, 40'(ia));
            host_u.put(1'b1, 8'h00, 16'h4000);
            host_u.get(8'h09, 5, v, len);
            check("energy clear", v, 40'h0);
            host_u.get(8'h0A, 5, v, len);
            check("charge clear", v, 40'h0);
            host_u.get(8'h0B, 2, v, len);
            check("overflow flag", v, 40'h0);
         end
      end
      // The count runs from three edges after one tick to the next tick.
      foreach (cts[i]) begin
         host_u.put(1'b1, 8'h01, {10'h0, cts[i], avs[i]});
         wait_out(n);
         wait_out(n);
         check("period", 40'(n + 3), 40'(pmr_pkg::CT_US[cts[i]] *
            pmr_pkg::AVG_N[avs[i]] * pmr_pkg::CLK_MHZ));
         check("conversions", 40'(convs), 40'(pmr_pkg::AVG_N[avs[i]]));
      end
      conclude();
   end
endmodule

bind pmr_result_regs pmr_result_regs_assertions chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
   .REQ(REQ), .REQ_VALID(REQ_VALID), .BYTE_NEXT(BYTE_NEXT), .RD_BYTE(RD_BYTE),
   .RD_LEN(RD_LEN), .CONV_TICK(CONV_TICK), .OUT_TICK(OUT_TICK));
